/* verilog/trd_pkg.sv */
// Purpose: Shared constants and carriers for the tag read-data-block command engine
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: Result codes and register offsets are local choices
package trd_pkg;

    // Register byte offsets
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_RESULT = 12'h004;
    localparam logic [11:0] REG_IRQ_STS = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00c;
    localparam logic [11:0] REG_BUSY = 12'h010;
    localparam logic [11:0] REG_ARG_BASE = 12'h020;
    localparam logic [11:0] REG_BUF_BASE = 12'h100;
    localparam logic [11:0] REG_BUF_END = 12'h500;

    // Argument byte offsets in the parameter area
    localparam int ARG_BLOCK = 'h00;
    localparam int ARG_COUNT = 'h01;
    localparam int ARG_OFFSET = 'h02;
    localparam int ARG_KEYSEL = 'h03;
    localparam int ARG_KEY = 'h04;
    localparam int KEY_BYTES = 'h06;
    localparam int ARG_BYTES = 11;

    // Key selector fields
    localparam int KEYSEL_KEY_B = 7;
    localparam int KEYSEL_USE_ARG = 6;
    localparam logic [5:0] KEY_IDX_MAX = 6'd39;

    // Command and result codes
    localparam logic [7:0] CMD_READ_DATA_BLOCK = 8'h04;
    localparam logic [7:0] RES_NO_ERROR = 8'h00;
    localparam logic [7:0] RES_BAD_CMD = 8'h01;
    localparam logic [7:0] RES_BAD_ARG = 8'h02;
    localparam logic [7:0] RES_AUTH_FAIL = 8'h03;
    localparam logic [7:0] RES_READ_FAIL = 8'h04;
    localparam logic [7:0] RES_BAD_TAG = 8'h05;
    localparam logic [7:0] RES_BUSY = 8'hff;
    localparam logic [7:0] RESULT_RST = 8'h00;

    // Tag memory geometry
    localparam int BLOCK_BYTES = 16;
    localparam logic [7:0] BIG_SECTOR_START = 8'h80;
    localparam logic [5:0] BIG_SECTOR_FIRST = 6'd32;

    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_AUTH_REQ = 3'b010,
        ST_AUTH_WAIT = 3'b011,
        ST_RD_REQ = 3'b100,
        ST_RD_WAIT = 3'b101,
        ST_COPY = 3'b110,
        ST_NEXT = 3'b111
    } trd_state_e;

    typedef struct packed {
        logic valid;
        logic auth;
        logic [7:0] block;
        logic key_b;
        logic [47:0] key;
    } trd_tag_req_s;

    typedef struct packed {
        logic done;
        logic ok;
        logic [127:0] data;
    } trd_tag_rsp_s;

endpackage : trd_pkg

/* verilog/trd_buf_mem.sv */
// Purpose: Byte-wide data buffer with one write port and a registered read port
// Assumes: Single clock, write and read may occur in the same cycle
// Notes: Read data appear one cycle after the address
`timescale 1ns/1ps
module trd_buf_mem #(
    parameter int DW = 8,
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule : trd_buf_mem

/* verilog/trd_cmd_engine.sv */
// Purpose: Command engine for the tag read-data-block operation behind an APB slave
// Assumes: Tag engine answers each request with one done pulse; key store answers at once
// Notes: Every APB transfer takes one wait state
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module trd_cmd_engine #(
    parameter int BUF_AW = 8,
    parameter logic [7:0] SUPPORTED_TAG = 8'h01
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [7:0] tag_type,
    output logic [5:0] key_idx,
    input wire logic [47:0] key_store_data,
    output trd_pkg::trd_tag_req_s tag_req,
    input wire trd_pkg::trd_tag_rsp_s tag_rsp
);
    trd_pkg::trd_state_e st_q;
    logic [7:0] args_q [0:trd_pkg::ARG_BYTES-1];
    logic [7:0] result_q;
    logic [1:0] sts_q;
    logic [1:0] mask_q;
    logic [7:0] blk_q;
    logic [7:0] left_q;
    logic [BUF_AW-1:0] ptr_q;
    logic [5:0] sec_q;
    logic [3:0] byte_q;
    logic [127:0] data_q;
    logic [47:0] key_q;
    logic [1:0] sts_set;
    logic start;
    logic busy;
    logic acc_done;
    logic wr_acc;
    logic [11:0] rel_buf;
    logic [11:0] rel_arg;
    logic [BUF_AW-1:0] buf_raddr;
    logic [7:0] buf_rdata;
    logic buf_we;
    logic [BUF_AW-1:0] buf_waddr;
    logic [7:0] buf_wdata;
    logic in_buf;
    logic in_arg;
    logic [47:0] arg_key;

    function automatic logic is_trailer(input logic [7:0] b);
        if (b < trd_pkg::BIG_SECTOR_START) begin
            return b[1:0] == 2'b11;
        end
        return b[3:0] == 4'hf;
    endfunction : is_trailer

    function automatic logic [5:0] sector_of(input logic [7:0] b);
        logic [7:0] rel;
        rel = b - trd_pkg::BIG_SECTOR_START;
        if (b < trd_pkg::BIG_SECTOR_START) begin
            return b[7:2];
        end
        return trd_pkg::BIG_SECTOR_FIRST + {2'b00, rel[7:4]};
    endfunction : sector_of

    assign busy = (st_q != trd_pkg::ST_IDLE);
    assign acc_done = psel && penable && pready;
    assign wr_acc = acc_done && pwrite;
    assign rel_buf = paddr - trd_pkg::REG_BUF_BASE;
    assign rel_arg = paddr - trd_pkg::REG_ARG_BASE;
    assign in_buf = (paddr >= trd_pkg::REG_BUF_BASE) && (paddr < trd_pkg::REG_BUF_END);
    assign in_arg = (paddr >= trd_pkg::REG_ARG_BASE) && (rel_arg[11:2] < 10'(trd_pkg::ARG_BYTES))
        && (paddr[1:0] == 2'b00);
    assign buf_raddr = rel_buf[BUF_AW+1:2];
    assign start = wr_acc && (paddr == trd_pkg::REG_CMD) && !busy;
    // Key bytes least significant first
    assign arg_key = {args_q[trd_pkg::ARG_KEY+5], args_q[trd_pkg::ARG_KEY+4],
        args_q[trd_pkg::ARG_KEY+3], args_q[trd_pkg::ARG_KEY+2],
        args_q[trd_pkg::ARG_KEY+1], args_q[trd_pkg::ARG_KEY]};

    // Buffer write port: engine while busy, software otherwise
    always_comb begin
        buf_we = 1'b0;
        buf_waddr = buf_raddr;
        buf_wdata = pwdata[7:0];
        if (st_q == trd_pkg::ST_COPY) begin
            buf_we = 1'b1;
            buf_waddr = ptr_q;
            buf_wdata = data_q[8*byte_q +: 8];
        end else if (wr_acc && in_buf && !busy) begin
            buf_we = 1'b1;
        end
    end

    trd_buf_mem #(
        .DW(8),
        .AW(BUF_AW)
    ) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .we(buf_we),
        .waddr(buf_waddr),
        .wdata(buf_wdata),
        .raddr(buf_raddr),
        .rdata_q(buf_rdata)
    );

    // APB answer: one wait state, read data registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !(in_buf || in_arg || paddr == trd_pkg::REG_CMD
                || paddr == trd_pkg::REG_RESULT || paddr == trd_pkg::REG_IRQ_STS
                || paddr == trd_pkg::REG_IRQ_MASK || paddr == trd_pkg::REG_BUSY);
            prdata <= '0;
            if (!pwrite) begin
                if (in_buf) begin
                    prdata <= {24'h000000, buf_rdata};
                end else if (in_arg) begin
                    prdata <= {24'h000000, args_q[rel_arg[5:2]]};
                end else if (paddr == trd_pkg::REG_RESULT) begin
                    prdata <= {24'h000000, result_q};
                end else if (paddr == trd_pkg::REG_IRQ_STS) begin
                    prdata <= {30'h00000000, sts_q};
                end else if (paddr == trd_pkg::REG_IRQ_MASK) begin
                    prdata <= {30'h00000000, mask_q};
                end else if (paddr == trd_pkg::REG_BUSY) begin
                    prdata <= {31'h00000000, busy};
                end
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Argument bytes, frozen while a command runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < trd_pkg::ARG_BYTES; i++) begin
                args_q[i] <= 8'h00;
            end
        end else if (wr_acc && in_arg && !busy) begin
            args_q[rel_arg[5:2]] <= pwdata[7:0];
        end
    end

    // Interrupt status, mask and output; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= 2'b00;
            mask_q <= 2'b00;
            irq <= 1'b0;
        end else begin
            if (wr_acc && paddr == trd_pkg::REG_IRQ_MASK) begin
                mask_q <= pwdata[1:0];
            end
            if (wr_acc && paddr == trd_pkg::REG_IRQ_STS) begin
                sts_q <= (sts_q & ~pwdata[1:0]) | sts_set;
            end else begin
                sts_q <= sts_q | sts_set;
            end
            irq <= |(sts_q & mask_q);
        end
    end

    always_comb begin
        sts_set = 2'b00;
        if (start && pwdata[7:0] != trd_pkg::CMD_READ_DATA_BLOCK) begin
            sts_set[trd_pkg::IRQ_ERR] = 1'b1;
        end
        if (st_q == trd_pkg::ST_CHECK && (tag_type != SUPPORTED_TAG || left_q == 8'h00
            || (!args_q[trd_pkg::ARG_KEYSEL][trd_pkg::KEYSEL_USE_ARG]
            && key_idx > trd_pkg::KEY_IDX_MAX))) begin
            sts_set[trd_pkg::IRQ_ERR] = 1'b1;
        end
        if ((st_q == trd_pkg::ST_AUTH_WAIT || st_q == trd_pkg::ST_RD_WAIT)
            && tag_rsp.done && !tag_rsp.ok) begin
            sts_set[trd_pkg::IRQ_ERR] = 1'b1;
        end
        if (st_q == trd_pkg::ST_COPY && byte_q == 4'hf && left_q == 8'h01) begin
            sts_set[trd_pkg::IRQ_DONE] = 1'b1;
        end
    end

    // Command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= trd_pkg::ST_IDLE;
            result_q <= trd_pkg::RESULT_RST;
            blk_q <= 8'h00;
            left_q <= 8'h00;
            ptr_q <= '0;
            sec_q <= 6'd0;
            byte_q <= 4'h0;
            data_q <= '0;
            key_q <= '0;
            key_idx <= 6'd0;
            tag_req <= '0;
        end else begin
            tag_req.valid <= 1'b0;
            unique case (st_q)
                trd_pkg::ST_IDLE: begin
                    if (start) begin
                        if (pwdata[7:0] == trd_pkg::CMD_READ_DATA_BLOCK) begin
                            st_q <= trd_pkg::ST_CHECK;
                            result_q <= trd_pkg::RES_BUSY;
                            blk_q <= args_q[trd_pkg::ARG_BLOCK];
                            left_q <= args_q[trd_pkg::ARG_COUNT];
                            ptr_q <= args_q[trd_pkg::ARG_OFFSET][BUF_AW-1:0];
                            key_idx <= args_q[trd_pkg::ARG_KEYSEL][5:0];
                        end else begin
                            result_q <= trd_pkg::RES_BAD_CMD;
                        end
                    end
                end
                trd_pkg::ST_CHECK: begin
                    key_q <= args_q[trd_pkg::ARG_KEYSEL][trd_pkg::KEYSEL_USE_ARG]
                        ? arg_key : key_store_data;
                    if (tag_type != SUPPORTED_TAG) begin
                        result_q <= trd_pkg::RES_BAD_TAG;
                        st_q <= trd_pkg::ST_IDLE;
                    end else if (left_q == 8'h00) begin
                        result_q <= trd_pkg::RES_BAD_ARG;
                        st_q <= trd_pkg::ST_IDLE;
                    end else if (!args_q[trd_pkg::ARG_KEYSEL][trd_pkg::KEYSEL_USE_ARG]
                        && key_idx > trd_pkg::KEY_IDX_MAX) begin
                        result_q <= trd_pkg::RES_BAD_ARG;
                        st_q <= trd_pkg::ST_IDLE;
                    end else if (is_trailer(blk_q)) begin
                        blk_q <= blk_q + 8'h01;
                    end else begin
                        st_q <= trd_pkg::ST_AUTH_REQ;
                    end
                end
                trd_pkg::ST_AUTH_REQ: begin
                    tag_req.valid <= 1'b1;
                    tag_req.auth <= 1'b1;
                    tag_req.block <= blk_q;
                    tag_req.key_b <= args_q[trd_pkg::ARG_KEYSEL][trd_pkg::KEYSEL_KEY_B];
                    tag_req.key <= key_q;
                    sec_q <= sector_of(blk_q);
                    st_q <= trd_pkg::ST_AUTH_WAIT;
                end
                trd_pkg::ST_AUTH_WAIT: begin
                    if (tag_rsp.done) begin
                        if (tag_rsp.ok) begin
                            st_q <= trd_pkg::ST_RD_REQ;
                        end else begin
                            result_q <= trd_pkg::RES_AUTH_FAIL;
                            st_q <= trd_pkg::ST_IDLE;
                        end
                    end
                end
                trd_pkg::ST_RD_REQ: begin
                    tag_req.valid <= 1'b1;
                    tag_req.auth <= 1'b0;
                    tag_req.block <= blk_q;
                    st_q <= trd_pkg::ST_RD_WAIT;
                end
                trd_pkg::ST_RD_WAIT: begin
                    if (tag_rsp.done) begin
                        if (tag_rsp.ok) begin
                            data_q <= tag_rsp.data;
                            byte_q <= 4'h0;
                            st_q <= trd_pkg::ST_COPY;
                        end else begin
                            result_q <= trd_pkg::RES_READ_FAIL;
                            st_q <= trd_pkg::ST_IDLE;
                        end
                    end
                end
                trd_pkg::ST_COPY: begin
                    ptr_q <= ptr_q + 1'b1;
                    byte_q <= byte_q + 4'h1;
                    if (byte_q == 4'hf) begin
                        left_q <= left_q - 8'h01;
                        blk_q <= blk_q + 8'h01;
                        if (left_q == 8'h01) begin
                            result_q <= trd_pkg::RES_NO_ERROR;
                            st_q <= trd_pkg::ST_IDLE;
                        end else begin
                            st_q <= trd_pkg::ST_NEXT;
                        end
                    end
                end
                trd_pkg::ST_NEXT: begin
                    if (is_trailer(blk_q)) begin
                        blk_q <= blk_q + 8'h01;
                    end else if (sector_of(blk_q) != sec_q) begin
                        st_q <= trd_pkg::ST_AUTH_REQ;
                    end else begin
                        st_q <= trd_pkg::ST_RD_REQ;
                    end
                end
            endcase
        end
    end

    // Checks
    sequence auth_fail_s;
        st_q == trd_pkg::ST_AUTH_WAIT && tag_rsp.done && !tag_rsp.ok;
    endsequence

    sequence auth_fail_end_s;
        result_q == trd_pkg::RES_AUTH_FAIL && st_q == trd_pkg::ST_IDLE && !tag_req.valid;
    endsequence

    cmd_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && pwdata[7:0] == trd_pkg::CMD_READ_DATA_BLOCK
        |=> st_q == trd_pkg::ST_CHECK && result_q == trd_pkg::RES_BUSY)
        else $error("Read command did not start");

    key_type_a: assert property (@(posedge pclk) disable iff (!presetn)
        tag_req.valid && tag_req.auth
        |-> tag_req.key_b == args_q[trd_pkg::ARG_KEYSEL][trd_pkg::KEYSEL_KEY_B])
        else $error("Key type does not follow selector bit 7");

    key_arg_a: assert property (@(posedge pclk) disable iff (!presetn)
        tag_req.valid && tag_req.auth && args_q[trd_pkg::ARG_KEYSEL][trd_pkg::KEYSEL_USE_ARG]
        |-> tag_req.key == arg_key)
        else $error("Argument key not used");

    auth_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == trd_pkg::ST_CHECK ##1 st_q == trd_pkg::ST_AUTH_REQ
        |=> tag_req.valid && tag_req.auth && tag_req.block == $past(blk_q))
        else $error("Start sector not authenticated first");

    auth_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
        auth_fail_s |=> auth_fail_end_s)
        else $error("Authentication failure not reported");

    skip_trailer_a: assert property (@(posedge pclk) disable iff (!presetn)
        tag_req.valid && !tag_req.auth |-> !is_trailer(tag_req.block))
        else $error("Trailer block was read");

    copy_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_q == trd_pkg::ST_COPY)
        |-> (st_q == trd_pkg::ST_COPY && buf_we)[*8] ##1 (st_q == trd_pkg::ST_COPY)[*8]
        ##1 st_q != trd_pkg::ST_COPY)
        else $error("Block copy not sixteen bytes");

    read_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == trd_pkg::ST_RD_WAIT && tag_rsp.done && !tag_rsp.ok
        |=> result_q == trd_pkg::RES_READ_FAIL && !busy)
        else $error("Read failure not reported");

    bad_tag_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == trd_pkg::ST_CHECK && tag_type != SUPPORTED_TAG
        |=> result_q == trd_pkg::RES_BAD_TAG && !tag_req.valid)
        else $error("Unsupported tag not reported");

    new_sector_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == trd_pkg::ST_NEXT && !is_trailer(blk_q) && sector_of(blk_q) != sec_q
        |=> ##1 tag_req.valid && tag_req.auth)
        else $error("New sector not authenticated");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == |($past(sts_q) & $past(mask_q)))
        else $error("Interrupt output wrong");
endmodule : trd_cmd_engine

/* verification/trd_tag_model.sv */
// Purpose: Tag and key store model facing the command engine
// Assumes: One answer per request after dly plus one idle cycles
// Notes: Answer ok and data fields toggle every cycle while no answer is due
`timescale 1ns/1ps
module trd_tag_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire trd_pkg::trd_tag_req_s tag_req,
    input wire logic [5:0] key_idx,
    input wire logic fail_auth,
    input wire logic fail_rd,
    input wire logic [3:0] dly,
    output trd_pkg::trd_tag_rsp_s tag_rsp,
    output logic [47:0] key_store_data
);
    logic pend_q;
    logic auth_q;
    logic [7:0] blk_q;
    logic [3:0] cnt_q;
    assign key_store_data = {6{2'b00, key_idx}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag_rsp <= '0;
            pend_q <= 1'b0;
            auth_q <= 1'b0;
            blk_q <= 8'h00;
            cnt_q <= 4'h0;
        end else begin
            tag_rsp.done <= 1'b0;
            tag_rsp.ok <= ~tag_rsp.ok;
            tag_rsp.data <= ~tag_rsp.data;
            if (tag_req.valid) begin
                pend_q <= 1'b1;
                cnt_q <= dly;
                auth_q <= tag_req.auth;
                blk_q <= tag_req.block;
            end else if (pend_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (pend_q) begin
                pend_q <= 1'b0;
                tag_rsp.done <= 1'b1;
                tag_rsp.ok <= auth_q ? !fail_auth : !fail_rd;
                for (int i = 0; i < 16; i++) begin
                    tag_rsp.data[8*i+:8] <= blk_q + 8'(i);
                end
            end
        end
    end
endmodule : trd_tag_model

/* verification/testbench.sv */
// Purpose: Self-checking bench for the read-data-block command engine
// Assumes: APB answer arrives within 50 cycles
// Notes: Tag data byte i of block b is b plus i
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] tag_type = 8'h01;
    logic [5:0] key_idx;
    logic [47:0] key_store_data;
    trd_pkg::trd_tag_req_s tag_req;
    trd_pkg::trd_tag_rsp_s tag_rsp;
    logic fail_auth = 1'b0;
    logic fail_rd = 1'b0;
    logic [3:0] dly = 4'h4;
    logic [47:0] exp_key;
    logic exp_kb;
    logic [1:0] mk = 2'b01;
    int failures = 0;
    int num_checks = 0;
    int auths = 0;
    always #12.5 pclk = ~pclk;
    trd_cmd_engine u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .tag_type(tag_type), .key_idx(key_idx),
        .key_store_data(key_store_data), .tag_req(tag_req), .tag_rsp(tag_rsp));
    trd_tag_model u_tag (.pclk(pclk), .presetn(presetn), .tag_req(tag_req), .key_idx(key_idx),
        .fail_auth(fail_auth), .fail_rd(fail_rd), .dly(dly), .tag_rsp(tag_rsp),
        .key_store_data(key_store_data));

    task chk(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) failures++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rd

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    // Every authentication request carries the chosen key
    always @(negedge pclk) begin
        if (tag_req.valid === 1'b1 && tag_req.auth === 1'b1) begin
            auths++;
            chk(tag_req.key, exp_key);
            chk(tag_req.key_b, exp_kb);
        end
    end

    task run(input logic [7:0] cm, b, n, o, ks, input logic [47:0] k, input logic [7:0] er);
        logic [31:0] r;
        logic e;
        logic [7:0] a[11];
        logic [7:0] blk;
        logic [7:0] q[$];
        int c, na, sec, ls;
        q.delete();
        exp_key = ks[6] ? k : {6{2'b00, ks[5:0]}};
        exp_kb = ks[7];
        auths = 0;
        a = '{b, n, o, ks, k[7:0], k[15:8], k[23:16], k[31:24], k[39:32], k[47:40], 8'h00};
        wr(trd_pkg::REG_IRQ_MASK, {30'h0, mk});
        for (int j = 0; j < 11; j++) wr(12'(trd_pkg::REG_ARG_BASE + 4 * j), {24'h0, a[j]});
        wr(trd_pkg::REG_CMD, {24'h0, cm});
        if (er == 8'h00 || er == trd_pkg::RES_AUTH_FAIL || er == trd_pkg::RES_READ_FAIL)
            rd(trd_pkg::REG_RESULT, {24'h0, trd_pkg::RES_BUSY});
        c = 0;
        do begin
            apb(1'b0, trd_pkg::REG_BUSY, 32'h0, r, e);
            c++;
        end while (r[0] !== 1'b0 && c < 300);
        chk(r[0], 0);
        rd(trd_pkg::REG_RESULT, {24'h0, er});
        if (cm == trd_pkg::CMD_READ_DATA_BLOCK) chk(key_idx, ks[5:0]);
        rd(trd_pkg::REG_IRQ_STS, {30'h0, er != 8'h00, er == 8'h00});
        chk(irq, |({er != 8'h00, er == 8'h00} & mk));
        wr(trd_pkg::REG_IRQ_STS, 32'h3);
        rd(trd_pkg::REG_IRQ_STS, 32'h0);
        chk(irq, 0);
        na = (er == trd_pkg::RES_AUTH_FAIL || er == trd_pkg::RES_READ_FAIL) ? 1 : 0;
        if (er == trd_pkg::RES_NO_ERROR) begin
            blk = b;
            ls = -1;
            c = 0;
            while (c < n) begin
                if (!(blk < 128 ? blk[1:0] == 2'h3 : blk[3:0] == 4'hf)) begin
                    sec = blk < 128 ? blk / 4 : 32 + (blk - 128) / 16;
                    if (sec != ls) na++;
                    ls = sec;
                    for (int i = 0; i < 16; i++) q.push_back(blk + 8'(i));
                    c++;
                end
                blk++;
            end
            foreach (q[j]) begin
                rd(12'(trd_pkg::REG_BUF_BASE + 4 * (o + j)), {24'h0, q[j]});
            end
        end
        chk(auths, na);
    endtask : run

    task results;
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    initial begin
        repeat (90000) @(posedge pclk);
        failures++;
        results();
    end

    initial begin
        logic [31:0] r;
        logic e;
        logic [7:0] n;
        void'($urandom(32'h9379));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(trd_pkg::REG_RESULT, 32'h0);
        rd(trd_pkg::REG_BUSY, 32'h0);
        apb(1'b0, 12'h014, 32'h0, r, e);
        chk(r, 0);
        chk(e, 1);
        run(8'h05, 8'h00, 8'h01, 8'h00, 8'h00, 48'h0, trd_pkg::RES_BAD_CMD);
        run(8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 48'h0, trd_pkg::RES_BAD_ARG);
        run(8'h04, 8'h00, 8'h01, 8'h00, 8'd40, 48'h0, trd_pkg::RES_BAD_ARG);
        mk = 2'b11;
        repeat (6) begin
            n = 8'(1 + $urandom % 8);
            dly <= 4'(4 + $urandom % 8);
            run(8'h04, 8'($urandom), n, 8'($urandom % (257 - 16 * n)),
                {2'($urandom), 6'($urandom % 40)}, {$urandom, 16'($urandom)},
                trd_pkg::RES_NO_ERROR);
        end
        run(8'h04, 8'd124, 8'h04, 8'h00, 8'hc5, 48'h0, trd_pkg::RES_NO_ERROR);
        run(8'h04, 8'd254, 8'h02, 8'd224, 8'h7f, 48'h665544332211, 8'h00);
        fail_auth <= 1'b1;
        run(8'h04, 8'd8, 8'h02, 8'h00, 8'h01, 48'h0, trd_pkg::RES_AUTH_FAIL);
        fail_auth <= 1'b0;
        fail_rd <= 1'b1;
        run(8'h04, 8'd8, 8'h02, 8'h00, 8'h81, 48'h0, trd_pkg::RES_READ_FAIL);
        fail_rd <= 1'b0;
        tag_type <= 8'h02;
        run(8'h04, 8'd8, 8'h01, 8'h00, 8'h02, 48'h0, trd_pkg::RES_BAD_TAG);
        results();
    end
endmodule : testbench
